/* File: core/tsm_pkg.sv */
// shared constants for the status and mode register pair
package tsm_pkg;

  // register port widths
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  // register addresses
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_IRQ = 3'h1;
  localparam logic [2:0] ADDR_MODE = 3'h2;

  // condition_status field positions
  localparam int unsigned ST_THERMAL_SHUTDOWN = 7;
  localparam int unsigned ST_AUX_INPUT_LEVEL = 6;
  localparam int unsigned ST_AUX_DRIVER_FAULT = 5;
  localparam int unsigned ST_LINE_DRIVER_FAULT = 4;
  localparam int unsigned ST_SUPPLY_LOW_WARNING = 3;
  localparam int unsigned ST_SUPPLY_UNDERVOLTAGE = 2;
  localparam int unsigned ST_LINE_LEVEL = 1;
  localparam int unsigned ST_OVERTEMP_WARNING = 0;

  // operating_mode_control field positions
  localparam int unsigned MD_SOFT_RESET = 7;
  localparam int unsigned MD_WAKEUP_DETECT_DISABLE = 6;
  localparam int unsigned MD_AUX_REGULATOR_DISABLE = 5;
  localparam int unsigned MD_SERIAL_PORT_SHARE_ENABLE = 4;
  localparam int unsigned MD_LOW_WARNING_IRQ_ENABLE = 3;
  localparam int unsigned MD_LINE_FILTER_BYPASS = 2;
  localparam int unsigned MD_INDICATOR2_LEVEL = 1;
  localparam int unsigned MD_INDICATOR1_OVERRIDE = 0;

  // latched interrupt field positions beyond the status mirror
  localparam int unsigned IRQ_WAKEUP = 6;

  // synchronised condition vector layout
  localparam int unsigned COND_W = 10;
  localparam int unsigned CD_WAKEUP = 8;
  localparam int unsigned CD_INDICATOR1_PIN = 9;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] IRQ_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  // status bits that raise a latched flag on their rising edge
  localparam logic [7:0] IRQ_EDGE_MASK = 8'hbd;

  // soft reset phase, one-hot
  typedef enum logic [1:0] {
    PH_NORMAL = 2'b01,
    PH_SOFT = 2'b10
  } tsm_phase_t;

  // whole state of the register pair
  typedef struct packed {
    tsm_phase_t phase;
    logic [7:0] mode;
    logic [7:0] irq;
    logic [7:0] status;
    logic [7:0] prev;
    logic wake_prev;
    logic [7:0] rdata;
    logic alert_n;
    logic ind1;
  } tsm_state_t;

endpackage : tsm_pkg

/* File: core/tsm_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for a vector of unrelated levels
module tsm_sync #(
  parameter int unsigned WIDTH = tsm_pkg::COND_W
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // both stages in one packed state
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } tsm_sync_t;

  tsm_sync_t s; // registered stages
  tsm_sync_t next_s; // next stages

  // first stage feeds only the second
  always_comb begin
    next_s = s;
    next_s.stage1 = async_i;
    next_s.stage2 = s.stage1;
  end

  // stage registers with synchronous reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.stage2;

endmodule : tsm_sync

/* File: core/tsm_regs.sv */
`timescale 1ns/1ps
module tsm_regs (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [2:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic THERMAL_SHUTDOWN_FLAG_I,
  input wire logic AUX_INPUT_PIN_I,
  input wire logic AUX_DRIVER_FAULT_I,
  input wire logic LINE_DRIVER_FAULT_I,
  input wire logic SUPPLY_LOW_WARNING_I,
  input wire logic SUPPLY_UNDERVOLTAGE_I,
  input wire logic LINE_LEVEL_I,
  input wire logic OVERTEMP_WARNING_I,
  input wire logic WAKEUP_DETECT_I,
  input wire logic INDICATOR1_PIN_INPUT_I,
  output logic FAULT_ALERT_OUT_N_O,
  output logic WAKEUP_DETECT_DISABLE_O,
  output logic AUX_REGULATOR_DISABLE_O,
  output logic SERIAL_PORT_SHARE_ENABLE_O,
  output logic LINE_FILTER_BYPASS_O,
  output logic INDICATOR2_LEVEL_O,
  output logic INDICATOR1_O
);

  tsm_pkg::tsm_state_t s; // registered state
  tsm_pkg::tsm_state_t next_s; // next state

  logic [tsm_pkg::COND_W-1:0] cond_raw; // raw condition levels
  logic [tsm_pkg::COND_W-1:0] cond_sync; // synchronised levels
  logic wr_mode; // write to mode register
  logic rd_irq; // read of interrupt register
  logic soft_wr; // write that starts soft reset
  logic soft_evt; // soft reset in progress or starting
  logic [7:0] set_vec; // new interrupt events this cycle

  // gather condition inputs in status bit order
  assign cond_raw = {
    INDICATOR1_PIN_INPUT_I,
    WAKEUP_DETECT_I,
    THERMAL_SHUTDOWN_FLAG_I,
    AUX_INPUT_PIN_I,
    AUX_DRIVER_FAULT_I,
    LINE_DRIVER_FAULT_I,
    SUPPLY_LOW_WARNING_I,
    SUPPLY_UNDERVOLTAGE_I,
    LINE_LEVEL_I,
    OVERTEMP_WARNING_I
  };

  tsm_sync #(
    .WIDTH(tsm_pkg::COND_W)
  ) u_sync (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .async_i(cond_raw),
    .sync_o(cond_sync)
  );

  // access decode
  assign wr_mode = REG_WR_I && (REG_ADDR_I == tsm_pkg::ADDR_MODE);
  assign rd_irq = REG_RD_I && (REG_ADDR_I == tsm_pkg::ADDR_IRQ);
  assign soft_wr = wr_mode && REG_WDATA_I[tsm_pkg::MD_SOFT_RESET] && (s.phase == tsm_pkg::PH_NORMAL);
  assign soft_evt = soft_wr || (s.phase == tsm_pkg::PH_SOFT);

  // interrupt event vector
  always_comb begin
    set_vec = 8'h00;
    set_vec = cond_sync[7:0] & ~s.prev & tsm_pkg::IRQ_EDGE_MASK;
    if (!s.mode[tsm_pkg::MD_LOW_WARNING_IRQ_ENABLE]) begin
      set_vec[tsm_pkg::ST_SUPPLY_LOW_WARNING] = 1'b0;
    end
    set_vec[tsm_pkg::IRQ_WAKEUP] = cond_sync[tsm_pkg::CD_WAKEUP] && !s.wake_prev
      && !s.mode[tsm_pkg::MD_WAKEUP_DETECT_DISABLE];
    if (soft_evt) begin
      set_vec = 8'h00;
    end
  end

  // next state of the whole register pair
  always_comb begin
    next_s = s;
    // edge history always tracks the inputs
    next_s.prev = cond_sync[7:0];
    next_s.wake_prev = cond_sync[tsm_pkg::CD_WAKEUP];
    next_s.status = cond_sync[7:0];
    next_s.irq = (rd_irq ? tsm_pkg::IRQ_RESET : s.irq) | set_vec;
    // read data, no side effect on status
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        tsm_pkg::ADDR_STATUS: begin
          next_s.rdata = s.status;
        end
        tsm_pkg::ADDR_IRQ: begin
          next_s.rdata = s.irq;
        end
        tsm_pkg::ADDR_MODE: begin
          next_s.rdata = s.mode;
        end
        default: begin
          next_s.rdata = tsm_pkg::RDATA_RESET;
        end
      endcase
    end
    // soft reset sequencing
    case (s.phase)
      tsm_pkg::PH_NORMAL: begin
        // plain mode write
        if (wr_mode) begin
          next_s.mode = REG_WDATA_I;
        end
        // clear status and flags on entry
        if (soft_wr) begin
          next_s.status = tsm_pkg::STATUS_RESET;
          next_s.irq = tsm_pkg::IRQ_RESET;
          next_s.phase = tsm_pkg::PH_SOFT;
        end
      end
      tsm_pkg::PH_SOFT: begin
        next_s.mode = tsm_pkg::MODE_RESET;
        next_s.status = tsm_pkg::STATUS_RESET;
        next_s.irq = tsm_pkg::IRQ_RESET;
        next_s.phase = tsm_pkg::PH_NORMAL;
      end
      default: begin
        next_s.phase = tsm_pkg::PH_NORMAL;
      end
    endcase
    next_s.alert_n = (next_s.irq == tsm_pkg::IRQ_RESET);
    next_s.ind1 = next_s.mode[tsm_pkg::MD_INDICATOR1_OVERRIDE] || cond_sync[tsm_pkg::CD_INDICATOR1_PIN];
  end

  // state register with synchronous reset
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      s.phase <= tsm_pkg::PH_NORMAL;
      s.mode <= tsm_pkg::MODE_RESET;
      s.irq <= tsm_pkg::IRQ_RESET;
      s.status <= tsm_pkg::STATUS_RESET;
      s.prev <= tsm_pkg::STATUS_RESET;
      s.wake_prev <= 1'b0;
      s.rdata <= tsm_pkg::RDATA_RESET;
      s.alert_n <= 1'b1;
      s.ind1 <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from state flops
  assign REG_RDATA_O = s.rdata;
  assign FAULT_ALERT_OUT_N_O = s.alert_n;
  assign WAKEUP_DETECT_DISABLE_O = s.mode[tsm_pkg::MD_WAKEUP_DETECT_DISABLE];
  assign AUX_REGULATOR_DISABLE_O = s.mode[tsm_pkg::MD_AUX_REGULATOR_DISABLE];
  assign SERIAL_PORT_SHARE_ENABLE_O = s.mode[tsm_pkg::MD_SERIAL_PORT_SHARE_ENABLE];
  assign LINE_FILTER_BYPASS_O = s.mode[tsm_pkg::MD_LINE_FILTER_BYPASS];
  assign INDICATOR2_LEVEL_O = s.mode[tsm_pkg::MD_INDICATOR2_LEVEL];
  assign INDICATOR1_O = s.ind1;

  // checks share one clock and reset
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // soft reset walk: flag up, then defaults back
  sequence soft_walk;
    ##1 s.mode[tsm_pkg::MD_SOFT_RESET] ##1 (s.mode == tsm_pkg::MODE_RESET && s.phase == tsm_pkg::PH_NORMAL);
  endsequence

  // wake edge seen while enabled and quiet
  sequence wake_edge;
    cond_sync[tsm_pkg::CD_WAKEUP] && !s.wake_prev && !s.mode[tsm_pkg::MD_WAKEUP_DETECT_DISABLE] && !soft_evt;
  endsequence

  // status tracks inputs three edges back
  status_live_a: assert property (
    // inputs may already be active while reset flushes the synchroniser
    $past(RST_N_I) && $past(RST_N_I, 2) && $past(RST_N_I, 3)
      && !$past(soft_evt) && !$past(soft_evt, 2) && !$past(soft_evt, 3)
      |-> s.status == $past(cond_raw[7:0], 3)
  ) else $error("status does not mirror conditions");

  // soft reset restores default mode
  soft_restore_a: assert property (
    soft_wr |-> soft_walk
  ) else $error("soft reset did not restore defaults");

  // status clear and alert release while flag set
  soft_clear_a: assert property (
    s.mode[tsm_pkg::MD_SOFT_RESET] |-> (s.status == tsm_pkg::STATUS_RESET) && s.alert_n
  ) else $error("status or alert active during soft reset");

  // no flag during and after soft reset
  soft_noirq_a: assert property (
    s.mode[tsm_pkg::MD_SOFT_RESET] |-> (s.irq == tsm_pkg::IRQ_RESET) ##1 (s.irq == tsm_pkg::IRQ_RESET)
  ) else $error("interrupt raised during soft reset");

  // flags never drop without a read or a soft reset
  irq_sticky_a: assert property (
    !rd_irq && !soft_evt |=> (s.irq & $past(s.irq)) == $past(s.irq)
  ) else $error("latched flag dropped without read");

  // read leaves only fresh events
  irq_clear_a: assert property (
    rd_irq && !soft_evt |=> s.irq == $past(set_vec)
  ) else $error("interrupt read did not clear flags");

  // alert low exactly while any flag set
  alert_level_a: assert property (
    s.alert_n == (s.irq == tsm_pkg::IRQ_RESET)
  ) else $error("alert does not match flags");

  // wake edge latches wake flag
  wake_set_a: assert property (
    wake_edge |=> s.irq[tsm_pkg::IRQ_WAKEUP] && !s.alert_n
  ) else $error("wake event not latched");

  // disabled detection keeps wake flag clear
  wake_off_a: assert property (
    s.mode[tsm_pkg::MD_WAKEUP_DETECT_DISABLE] && !s.irq[tsm_pkg::IRQ_WAKEUP] |=> !s.irq[tsm_pkg::IRQ_WAKEUP]
  ) else $error("wake flag set while detection disabled");

  // warning flag held off without enable
  warn_gate_a: assert property (
    !s.mode[tsm_pkg::MD_LOW_WARNING_IRQ_ENABLE] && !s.irq[tsm_pkg::ST_SUPPLY_LOW_WARNING]
      |=> !s.irq[tsm_pkg::ST_SUPPLY_LOW_WARNING]
  ) else $error("supply warning flag set while disabled");

  // first indicator override or pin follow
  ind1_follow_a: assert property (
    s.ind1 == (s.mode[tsm_pkg::MD_INDICATOR1_OVERRIDE] || $past(cond_sync[tsm_pkg::CD_INDICATOR1_PIN]))
  ) else $error("indicator one wrong");

  // status read changes nothing latched
  status_read_a: assert property (
    REG_RD_I && REG_ADDR_I == tsm_pkg::ADDR_STATUS && !soft_evt |=> s.rdata == $past(s.status)
      && (s.irq & $past(s.irq)) == $past(s.irq)
  ) else $error("status read returned wrong value");

  // plain mode write lands next edge
  mode_write_a: assert property (
    wr_mode && !soft_evt |=> s.mode == $past(REG_WDATA_I)
      && AUX_REGULATOR_DISABLE_O == $past(REG_WDATA_I[tsm_pkg::MD_AUX_REGULATOR_DISABLE])
  ) else $error("mode write not taken");

endmodule : tsm_regs

/* File: verif/tsm_host.sv */
`timescale 1ns/1ps
// host side of the register port, strobes launched on falling edges
module tsm_host (
  input wire logic clk_i,
  output logic [2:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  // idle port values from time zero
  initial begin
    addr_o = 3'h0;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end

  // one write, address and data held through the taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    // released data shows no stale value
    wdata_o = ~d;
  endtask : wr

  // one read strobe, a single cycle long
  task automatic rd(input logic [2:0] a);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
  endtask : rd
endmodule : tsm_host

/* File: verif/tsm_regs_bench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin failures++; \
  $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end
module tsm_regs_bench;
  logic CLK_I;
  logic RST_N_I;
  logic [2:0] addr;
  logic wr;
  logic rd;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] cond;  // status-ordered condition levels
  logic wake;
  logic pin;
  logic alert_n;
  logic [5:0] outs;  // mode outputs 6,5,4,2,1 and indicator 1
  logic [7:0] exp_q[$];  // expected read data, oldest first
  logic [7:0] e;
  logic [7:0] d;
  logic [7:0] prev;
  logic [7:0] flags;
  logic [15:0] lfsr;
  int failures;
  int total_checks;

  tsm_host tsm_host_i (.clk_i(CLK_I), .addr_o(addr), .wr_o(wr), .rd_o(rd), .wdata_o(wdata));

  tsm_regs tsm_regs_i (
    .CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .THERMAL_SHUTDOWN_FLAG_I(cond[7]),
    .AUX_INPUT_PIN_I(cond[6]), .AUX_DRIVER_FAULT_I(cond[5]), .LINE_DRIVER_FAULT_I(cond[4]),
    .SUPPLY_LOW_WARNING_I(cond[3]), .SUPPLY_UNDERVOLTAGE_I(cond[2]), .LINE_LEVEL_I(cond[1]),
    .OVERTEMP_WARNING_I(cond[0]), .WAKEUP_DETECT_I(wake), .INDICATOR1_PIN_INPUT_I(pin),
    .FAULT_ALERT_OUT_N_O(alert_n), .WAKEUP_DETECT_DISABLE_O(outs[5]), .AUX_REGULATOR_DISABLE_O(outs[4]),
    .SERIAL_PORT_SHARE_ENABLE_O(outs[3]), .LINE_FILTER_BYPASS_O(outs[2]),
    .INDICATOR2_LEVEL_O(outs[1]), .INDICATOR1_O(outs[0])
  );

  // free-running 50 MHz clock
  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end

  // pseudo-random source
  function automatic logic [15:0] step(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : step

  // read with its expected value noted first
  task automatic rd_exp(input logic [2:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    tsm_host_i.rd(a);
  endtask : rd_exp

  // past the two-flop synchroniser and the status flop
  task automatic settle;
    repeat (4) @(negedge CLK_I);
  endtask : settle

  // mode outputs against a mode value
  task automatic chk_out(input logic [7:0] m);
    `CHK(outs, {m[6], m[5], m[4], m[2], m[1], m[0] | pin})
  endtask : chk_out

  // read data lands at the taking edge, compared just after it
  always @(posedge CLK_I) begin
    if (rd === 1'b1) begin
      #1;
      e = exp_q.pop_front();
      `CHK(rdata, e)
    end
  end

  // verdict and end of run
  task automatic final_report;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  // hang guard, far beyond the few hundred cycles needed
  initial begin
    #200000;
    failures++;
    final_report();
  end

  // main sequence
  initial begin
    RST_N_I = 1'b0;
    cond = 8'h00;
    wake = 1'b0;
    pin = 1'b0;
    lfsr = 16'hd304;
    repeat (10) @(negedge CLK_I);
    RST_N_I = 1'b1;
    // reset values, unmapped address reads zero
    rd_exp(3'h0, 8'h00);
    rd_exp(3'h2, 8'h00);
    rd_exp(3'h1, 8'h00);
    rd_exp(3'h5, 8'h00);
    `CHK(alert_n, 1'b1)
    chk_out(8'h00);
    $display("test reset done");
    // random mode values with random indicator pin
    for (int i = 0; i < 8; i++) begin
      lfsr = step(lfsr);
      d = lfsr[7:0] & 8'h7f;
      pin = lfsr[8];
      tsm_host_i.wr(3'h2, d);
      settle();
      rd_exp(3'h2, d);
      chk_out(d);
    end
    $display("test mode done");
    // random condition levels mirrored live, writes to status ignored
    tsm_host_i.wr(3'h2, 8'h08);
    prev = 8'h00;
    flags = 8'h00;
    for (int i = 0; i < 8; i++) begin
      lfsr = step(lfsr);
      cond = lfsr[7:0];
      flags = flags | (cond & ~prev & 8'hbd);
      prev = cond;
      settle();
      tsm_host_i.wr(3'h0, ~cond);
      rd_exp(3'h0, cond);
    end
    cond = 8'h00;
    settle();
    `CHK(alert_n, flags == 8'h00)
    rd_exp(3'h1, flags);
    `CHK(alert_n, 1'b1)
    rd_exp(3'h1, 8'h00);
    $display("test status done");
    // wake event enabled, then masked along with the supply warning
    wake = 1'b1;
    settle();
    wake = 1'b0;
    rd_exp(3'h1, 8'h40);
    tsm_host_i.wr(3'h2, 8'h40);
    wake = 1'b1;
    cond = 8'h08;
    settle();
    wake = 1'b0;
    cond = 8'h00;
    settle();
    rd_exp(3'h1, 8'h00);
    $display("test interrupt done");
    // soft reset with a pending flag
    tsm_host_i.wr(3'h2, 8'h5e);
    cond = 8'h01;
    settle();
    cond = 8'h00;
    settle();
    `CHK(alert_n, 1'b0)
    // live levels that raise no flag, so a cleared status is visible
    cond = 8'h42;
    tsm_host_i.wr(3'h2, 8'h80);
    `CHK(alert_n, 1'b1)
    rd_exp(3'h0, 8'h00);
    settle();
    rd_exp(3'h2, 8'h00);
    rd_exp(3'h1, 8'h00);
    rd_exp(3'h0, 8'h42);
    chk_out(8'h00);
    $display("test soft reset done");
    final_report();
  end
endmodule : tsm_regs_bench
